// ---- urcrs_channel.sv ----
// Behaviour
// - Power-up loads divisor high 00, low 01
// - Hardware reset pin leaves divisor high and low untouched, clears divisor fraction
// - Reset clears modem change indicator bits
// - Modem status upper bits show inverted pins, or modem control bits in loopback
// - Select high, 16 mode: interrupt driven low
// - Select low: interrupt outputs three-stated after reset
// - Summary bits 7:4 show receive-ready per channel
// - Summary low bits invert transmit-ready levels
// - Summary select low drives summary onto bus
`timescale 1ns/1ps
`default_nettype none
`include "urcrs_params.svh"

module urcrs_channel #(
   parameter int unsigned CHAN = 0
) (
   input wire logic sys_clk, // 200 MHz clock
   input wire logic rstn, // Power-up reset, active low
   input wire urcrs_pkg::urcrs_pins_t pins, // Asynchronous pins
   input wire logic [7:0] rx_data_in, // Receive holding data
   input wire logic [7:0] irq_src_in, // Interrupt source code
   input wire logic [7:0] line_status_in, // Line status from datapath
   input wire logic tx_serial_in, // Serial data from transmitter
   input wire logic rx_avail_in, // Receive data available
   input wire logic tx_space_in, // Transmit space available
   input wire logic [3:0] all_rx_ready_n, // Receive-ready levels, channels A-D
   input wire logic [3:0] all_tx_ready_n, // Transmit-ready levels, channels A-D
   output logic [7:0] data_out, // Read data bus
   output logic data_oe_n, // Data bus enable, low drives
   output logic tx_out, // Serial transmit pin
   output logic infrared_tx_out, // Infrared transmit pin
   output logic rts_n_out, // Request to send, active low
   output logic dtr_n_out, // Data terminal ready, active low
   output logic rx_ready_n_out, // Receive ready, active low
   output logic tx_ready_n_out, // Transmit ready, active low
   output logic int_out, // Interrupt, 16 mode
   output logic int_oe_n, // Interrupt enable, low drives
   output logic irq_n_out, // Interrupt request, 68 mode
   output logic irq_n_oe_n, // Request enable, low drives
   output urcrs_pkg::urcrs_divisor_t divisor_out // Divisor to baud generator
);
   import urcrs_pkg::*;

   urcrs_pins_t ps;
   urcrs_sel_t sel;
   logic hw_rst, rd_act, wr_act, rd_act_q, wr_act_q, wr_pulse, rd_end;
   logic [7:0] divisor_low_byte_q, divisor_high_byte_q, divisor_fraction_q;
   logic [7:0] irq_enable_reg_q, fifo_control_reg_q, line_control_reg_q;
   logic [7:0] modem_control_reg_q, enhanced_feature_reg_q, scratch_reg_q;
   logic [7:0] resume_char_one_q, resume_char_two_q, pause_char_one_q, pause_char_two_q;
   logic [7:0] irq_source_reg_q, line_status_reg_q, fifo_ready_summary_q;
   logic [7:0] modem_status_reg, rd_mux;
   logic [3:0] modem_delta_q, modem_stat, modem_prev_q, rx_vec, tx_vec;
   logic irq_active, enh_en;

   // ==========================================================
   // Pin synchronisation
   urcrs_sync #(
      .W($bits(urcrs_pins_t)),
      .RST_VAL(`URCRS_SYNC_RST)
   ) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .din(pins),
      .dout(ps)
   );

   // Register selection from address, line control and enable bit
   function automatic urcrs_sel_t reg_sel(input logic [2:0] a, input logic [7:0] line_control_reg,
                                          input logic enh);
      urcrs_sel_t s;
      s = URCRS_SEL_DATA;
      if (a == `URCRS_OFF_DATA && line_control_reg[`URCRS_LCR_DIV_BIT]) begin
         s = URCRS_SEL_DIV_LOW;
      end else if (a == `URCRS_OFF_DATA) begin
         s = URCRS_SEL_DATA;
      end else if (a == `URCRS_OFF_IER && line_control_reg[`URCRS_LCR_DIV_BIT]) begin
         s = URCRS_SEL_DIV_HIGH;
      end else if (a == `URCRS_OFF_IER) begin
         s = URCRS_SEL_IER;
      end else if (a == `URCRS_OFF_LCR) begin
         s = URCRS_SEL_LCR;
      end else if (line_control_reg == `URCRS_LCR_KEY) begin
         if (a == `URCRS_OFF_ISR) begin
            s = URCRS_SEL_EFR;
         end else if (a == `URCRS_OFF_MCR) begin
            s = URCRS_SEL_RESUME_CHAR_ONE;
         end else if (a == `URCRS_OFF_LSR) begin
            s = URCRS_SEL_RESUME_CHAR_TWO;
         end else if (a == `URCRS_OFF_MSR) begin
            s = URCRS_SEL_PAUSE_CHAR_ONE;
         end else begin
            s = URCRS_SEL_PAUSE_CHAR_TWO;
         end
      end else if (a == `URCRS_OFF_ISR && line_control_reg[`URCRS_LCR_DIV_BIT] && enh) begin
         s = URCRS_SEL_FRAC;
      end else if (a == `URCRS_OFF_ISR) begin
         s = URCRS_SEL_ISR;
      end else if (a == `URCRS_OFF_MCR) begin
         s = URCRS_SEL_MCR;
      end else if (a == `URCRS_OFF_LSR) begin
         s = URCRS_SEL_LSR;
      end else if (a == `URCRS_OFF_MSR) begin
         s = URCRS_SEL_MSR;
      end else begin
         s = URCRS_SEL_SPR;
      end
      return s;
   endfunction

   // ==========================================================
   // Bus strobes for both bus styles
   assign hw_rst = ps.hw_reset;
   assign enh_en = enhanced_feature_reg_q[`URCRS_EFR_ENH_BIT];
   assign rd_act = !ps.cs_n && (ps.mode_68 ? ps.rw : !ps.ior_n);
   assign wr_act = !ps.cs_n && (ps.mode_68 ? !ps.rw : !ps.iow_n);
   assign wr_pulse = wr_act && !wr_act_q;
   assign rd_end = rd_act_q && !rd_act;
   assign sel = reg_sel(ps.addr, line_control_reg_q, enh_en);

   // Strobe history for edge detection
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
      end else begin
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
      end
   end

   // ==========================================================
   // Divisor latches, loaded with power-up values by power-up reset only
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         divisor_low_byte_q <= `URCRS_RST_DIV_LOW;
         divisor_high_byte_q <= `URCRS_RST_DIV_HIGH;
      end else if (wr_pulse && sel == URCRS_SEL_DIV_LOW) begin
         divisor_low_byte_q <= ps.wdata;
      end else if (wr_pulse && sel == URCRS_SEL_DIV_HIGH) begin
         divisor_high_byte_q <= ps.wdata;
      end
   end

   // Control registers; enhanced bits change only while enabled
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         divisor_fraction_q <= `URCRS_RST_ZERO;
         irq_enable_reg_q <= `URCRS_RST_ZERO;
         fifo_control_reg_q <= `URCRS_RST_ZERO;
         line_control_reg_q <= `URCRS_RST_ZERO;
         modem_control_reg_q <= `URCRS_RST_ZERO;
         enhanced_feature_reg_q <= `URCRS_RST_ZERO;
         scratch_reg_q <= `URCRS_RST_SPR;
      end else if (hw_rst) begin
         divisor_fraction_q <= `URCRS_RST_ZERO;
         irq_enable_reg_q <= `URCRS_RST_ZERO;
         fifo_control_reg_q <= `URCRS_RST_ZERO;
         line_control_reg_q <= `URCRS_RST_ZERO;
         modem_control_reg_q <= `URCRS_RST_ZERO;
         enhanced_feature_reg_q <= `URCRS_RST_ZERO;
         scratch_reg_q <= `URCRS_RST_SPR;
      end else if (wr_pulse) begin
         if (sel == URCRS_SEL_FRAC) begin
            divisor_fraction_q <= ps.wdata;
         end else if (sel == URCRS_SEL_IER) begin
            irq_enable_reg_q <= enh_en ? ps.wdata : {irq_enable_reg_q[7:4], ps.wdata[3:0]};
         end else if (sel == URCRS_SEL_ISR) begin
            fifo_control_reg_q <= enh_en ? ps.wdata :
                                  {ps.wdata[7:6], fifo_control_reg_q[5:4], ps.wdata[3:0]};
         end else if (sel == URCRS_SEL_LCR) begin
            line_control_reg_q <= ps.wdata;
         end else if (sel == URCRS_SEL_MCR) begin
            modem_control_reg_q <= enh_en ? ps.wdata :
                                   {modem_control_reg_q[7:5], ps.wdata[4:0]};
         end else if (sel == URCRS_SEL_EFR) begin
            enhanced_feature_reg_q <= ps.wdata;
         end else if (sel == URCRS_SEL_SPR) begin
            scratch_reg_q <= ps.wdata;
         end
      end
   end

   // Flow-control characters
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         resume_char_one_q <= `URCRS_RST_ZERO;
         resume_char_two_q <= `URCRS_RST_ZERO;
         pause_char_one_q <= `URCRS_RST_ZERO;
         pause_char_two_q <= `URCRS_RST_ZERO;
      end else if (hw_rst) begin
         resume_char_one_q <= `URCRS_RST_ZERO;
         resume_char_two_q <= `URCRS_RST_ZERO;
         pause_char_one_q <= `URCRS_RST_ZERO;
         pause_char_two_q <= `URCRS_RST_ZERO;
      end else if (wr_pulse && sel == URCRS_SEL_RESUME_CHAR_ONE) begin
         resume_char_one_q <= ps.wdata;
      end else if (wr_pulse && sel == URCRS_SEL_RESUME_CHAR_TWO) begin
         resume_char_two_q <= ps.wdata;
      end else if (wr_pulse && sel == URCRS_SEL_PAUSE_CHAR_ONE) begin
         pause_char_one_q <= ps.wdata;
      end else if (wr_pulse && sel == URCRS_SEL_PAUSE_CHAR_TWO) begin
         pause_char_two_q <= ps.wdata;
      end
   end

   // Status copies from the datapath
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_source_reg_q <= `URCRS_RST_ISR;
         line_status_reg_q <= `URCRS_RST_LSR;
      end else if (hw_rst) begin
         irq_source_reg_q <= `URCRS_RST_ISR;
         line_status_reg_q <= `URCRS_RST_LSR;
      end else begin
         irq_source_reg_q <= irq_src_in;
         line_status_reg_q <= line_status_in;
      end
   end

   // ==========================================================
   // Modem status: live inverted pins, or loopback from modem control
   always_comb begin
      if (modem_control_reg_q[`URCRS_MCR_LOOP_BIT]) begin
         modem_stat = {modem_control_reg_q[3], modem_control_reg_q[2],
                       modem_control_reg_q[0], modem_control_reg_q[1]};
      end else begin
         modem_stat = ~{ps.cd_n, ps.ri_n, ps.dsr_n, ps.cts_n};
      end
   end
   assign modem_status_reg = {modem_stat, modem_delta_q};

   // Change indicators; a new change wins over the clearing read
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         modem_delta_q <= 4'h0;
         modem_prev_q <= 4'h0;
      end else if (hw_rst) begin
         modem_delta_q <= 4'h0;
         modem_prev_q <= modem_stat;
      end else begin
         modem_prev_q <= modem_stat;
         modem_delta_q <= ((rd_end && sel == URCRS_SEL_MSR) ? 4'h0 : modem_delta_q)
                          | {modem_stat[3] ^ modem_prev_q[3],
                             modem_prev_q[2] & !modem_stat[2],
                             modem_stat[1:0] ^ modem_prev_q[1:0]};
      end
   end

   // ==========================================================
   // Ready pins and chip-wide summary
   always_comb begin
      rx_vec = all_rx_ready_n;
      tx_vec = all_tx_ready_n;
      rx_vec[CHAN[1:0]] = rx_ready_n_out;
      tx_vec[CHAN[1:0]] = tx_ready_n_out;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rx_ready_n_out <= 1'b1;
         tx_ready_n_out <= 1'b0;
         fifo_ready_summary_q <= `URCRS_RST_SUMMARY;
      end else if (hw_rst) begin
         rx_ready_n_out <= 1'b1;
         tx_ready_n_out <= 1'b0;
         fifo_ready_summary_q <= `URCRS_RST_SUMMARY;
      end else begin
         rx_ready_n_out <= !rx_avail_in;
         tx_ready_n_out <= !tx_space_in;
         fifo_ready_summary_q <= {rx_vec, ~tx_vec};
      end
   end

   // ==========================================================
   // Read path; summary select overrides the register read
   always_comb begin
      if (sel == URCRS_SEL_DIV_LOW) begin
         rd_mux = divisor_low_byte_q;
      end else if (sel == URCRS_SEL_DIV_HIGH) begin
         rd_mux = divisor_high_byte_q;
      end else if (sel == URCRS_SEL_FRAC) begin
         rd_mux = divisor_fraction_q;
      end else if (sel == URCRS_SEL_IER) begin
         rd_mux = irq_enable_reg_q;
      end else if (sel == URCRS_SEL_ISR) begin
         rd_mux = irq_source_reg_q;
      end else if (sel == URCRS_SEL_LCR) begin
         rd_mux = line_control_reg_q;
      end else if (sel == URCRS_SEL_MCR) begin
         rd_mux = modem_control_reg_q;
      end else if (sel == URCRS_SEL_LSR) begin
         rd_mux = line_status_reg_q;
      end else if (sel == URCRS_SEL_MSR) begin
         rd_mux = modem_status_reg;
      end else if (sel == URCRS_SEL_SPR) begin
         rd_mux = scratch_reg_q;
      end else if (sel == URCRS_SEL_EFR) begin
         rd_mux = enhanced_feature_reg_q;
      end else if (sel == URCRS_SEL_RESUME_CHAR_ONE) begin
         rd_mux = resume_char_one_q;
      end else if (sel == URCRS_SEL_RESUME_CHAR_TWO) begin
         rd_mux = resume_char_two_q;
      end else if (sel == URCRS_SEL_PAUSE_CHAR_ONE) begin
         rd_mux = pause_char_one_q;
      end else if (sel == URCRS_SEL_PAUSE_CHAR_TWO) begin
         rd_mux = pause_char_two_q;
      end else begin
         rd_mux = rx_data_in;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         data_out <= 8'h00;
         data_oe_n <= 1'b1;
      end else if (!ps.summary_select_n) begin
         data_out <= fifo_ready_summary_q;
         data_oe_n <= 1'b0;
      end else begin
         data_out <= rd_mux;
         data_oe_n <= !rd_act;
      end
   end

   // ==========================================================
   // Serial and modem-control pins
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tx_out <= 1'b1;
         infrared_tx_out <= 1'b0;
      end else if (hw_rst || modem_control_reg_q[`URCRS_MCR_LOOP_BIT]) begin
         tx_out <= 1'b1;
         infrared_tx_out <= 1'b0;
      end else begin
         tx_out <= tx_serial_in;
         infrared_tx_out <= !tx_serial_in;
      end
   end

   // Loopback keeps the modem outputs idle
   assign rts_n_out = !modem_control_reg_q[1] || modem_control_reg_q[`URCRS_MCR_LOOP_BIT];
   assign dtr_n_out = !modem_control_reg_q[0] || modem_control_reg_q[`URCRS_MCR_LOOP_BIT];

   // Interrupt pins: select high drives, else enabled by modem control bit 3
   assign irq_active = !irq_source_reg_q[0];
   assign int_out = irq_active;
   assign int_oe_n = ps.mode_68 ||
                     !(ps.irq_drive_select || modem_control_reg_q[`URCRS_MCR_OUT2_BIT]);
   assign irq_n_out = 1'b0;
   assign irq_n_oe_n = !ps.mode_68 || !irq_active ||
                       !(ps.irq_drive_select || modem_control_reg_q[`URCRS_MCR_OUT2_BIT]);
   assign divisor_out = '{high: divisor_high_byte_q, low: divisor_low_byte_q,
                          fraction: divisor_fraction_q};

   // ==========================================================
   // Checks
   logic first_q;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   a_div_powerup: assert property (@(posedge sys_clk) disable iff (!rstn) first_q |-> divisor_low_byte_q == 8'h01 && divisor_high_byte_q == 8'h00) else $error("divisor power-up value wrong");
   a_div_hold: assert property (@(posedge sys_clk) disable iff (!rstn) hw_rst |=> $stable(divisor_low_byte_q) && $stable(divisor_high_byte_q)) else $error("divisor changed by reset pin");
   a_delta_clear: assert property (@(posedge sys_clk) disable iff (!rstn) hw_rst |=> modem_status_reg[3:0] == 4'h0) else $error("change bits not cleared");
   a_stat_invert: assert property (@(posedge sys_clk) disable iff (!rstn) $past(hw_rst) && !modem_control_reg_q[4] |-> modem_status_reg[7:4] == ~{ps.cd_n, ps.ri_n, ps.dsr_n, ps.cts_n}) else $error("status bits not inverted pins");
   a_int_driven: assert property (@(posedge sys_clk) disable iff (!rstn) hw_rst && ps.irq_drive_select && !ps.mode_68 ##1 $stable(ps.irq_drive_select) && $stable(ps.mode_68) |-> !int_oe_n && !int_out) else $error("interrupt not driven low");
   a_int_tristate: assert property (@(posedge sys_clk) disable iff (!rstn) hw_rst && !ps.irq_drive_select ##1 !ps.irq_drive_select |-> int_oe_n && irq_n_oe_n) else $error("interrupt not three-stated");
   a_sum_rx: assert property (@(posedge sys_clk) disable iff (!rstn) !hw_rst |=> fifo_ready_summary_q[7:4] == $past(rx_vec)) else $error("summary receive bits wrong");
   a_sum_tx: assert property (@(posedge sys_clk) disable iff (!rstn) !hw_rst |=> fifo_ready_summary_q[3:0] == ~$past(tx_vec)) else $error("summary transmit bits wrong");
   a_sum_drive: assert property (@(posedge sys_clk) disable iff (!rstn) !ps.summary_select_n |=> !data_oe_n && data_out == $past(fifo_ready_summary_q)) else $error("summary not on bus");
   a_reset_load: assert property (@(posedge sys_clk) disable iff (!rstn) hw_rst |=> line_control_reg_q == 8'h00 && scratch_reg_q == 8'hff && irq_source_reg_q == 8'h01 && line_status_reg_q == 8'h60 && tx_out && !infrared_tx_out && rx_ready_n_out && !tx_ready_n_out) else $error("reset values wrong");
endmodule // urcrs_channel

`default_nettype wire

// ---- urcrs_params.svh ----
`ifndef URCRS_PARAMS_SVH
`define URCRS_PARAMS_SVH

// ==========================================================
// Register offsets on the three address lines
`define URCRS_OFF_DATA 3'h0
`define URCRS_OFF_IER 3'h1
`define URCRS_OFF_ISR 3'h2
`define URCRS_OFF_LCR 3'h3
`define URCRS_OFF_MCR 3'h4
`define URCRS_OFF_LSR 3'h5
`define URCRS_OFF_MSR 3'h6
`define URCRS_OFF_SPR 3'h7

// ==========================================================
// Reset values
`define URCRS_RST_DIV_LOW 8'h01
`define URCRS_RST_DIV_HIGH 8'h00
`define URCRS_RST_ZERO 8'h00
`define URCRS_RST_ISR 8'h01
`define URCRS_RST_LSR 8'h60
`define URCRS_RST_SPR 8'hff
`define URCRS_RST_SUMMARY 8'hff

// ==========================================================
// Access keys and field positions
`define URCRS_LCR_KEY 8'hbf
`define URCRS_LCR_DIV_BIT 7
`define URCRS_EFR_ENH_BIT 4
`define URCRS_MCR_LOOP_BIT 4
`define URCRS_MCR_OUT2_BIT 3
`define URCRS_SYNC_RST 23'h7fffff

`endif

// ---- urcrs_pkg.sv ----
`default_nettype none

package urcrs_pkg;

   // ==========================================================
   // Pins that cross into the clock domain
   typedef struct packed {
      logic hw_reset;
      logic irq_drive_select;
      logic mode_68;
      logic summary_select_n;
      logic cs_n;
      logic ior_n;
      logic iow_n;
      logic rw;
      logic [2:0] addr;
      logic [7:0] wdata;
      logic cts_n;
      logic dsr_n;
      logic ri_n;
      logic cd_n;
   } urcrs_pins_t;

   // ==========================================================
   // Divisor values handed to the baud generator
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
      logic [7:0] fraction;
   } urcrs_divisor_t;

   // ==========================================================
   // Decoded register selection
   typedef enum {
      URCRS_SEL_DATA, URCRS_SEL_DIV_LOW, URCRS_SEL_DIV_HIGH, URCRS_SEL_FRAC,
      URCRS_SEL_IER, URCRS_SEL_ISR, URCRS_SEL_LCR, URCRS_SEL_MCR,
      URCRS_SEL_LSR, URCRS_SEL_MSR, URCRS_SEL_SPR, URCRS_SEL_EFR,
      URCRS_SEL_RESUME_CHAR_ONE, URCRS_SEL_RESUME_CHAR_TWO, URCRS_SEL_PAUSE_CHAR_ONE, URCRS_SEL_PAUSE_CHAR_TWO
   } urcrs_sel_t;

endpackage

`default_nettype wire

// ---- urcrs_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for asynchronous pins
module urcrs_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic sys_clk, // System clock
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic [W-1:0] din, // Asynchronous inputs
   output logic [W-1:0] dout // Synchronised outputs
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // urcrs_sync

`default_nettype wire

// ---- urcrs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ====================
// Host bus model, one access at a time
module urcrs_host_model (
   input wire logic sys_clk, // Clock
   input wire logic [7:0] data_out, // Read data
   input wire logic data_oe_n, // Bus driven when low
   output logic cs_n, // Chip select
   output logic ior_n, // Read strobe
   output logic iow_n, // Write strobe
   output logic summary_select_n, // Summary select
   output logic [2:0] addr, // Offset
   output logic [7:0] wdata // Write data
);
   // Idle levels
   initial begin
      {cs_n, ior_n, iow_n, summary_select_n} = 4'hf;
      addr = 3'h0;
      wdata = 8'h00;
   end
   // Write: strobe held past the pin synchroniser, then spaced out
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      {cs_n, iow_n} <= 2'b00;
      repeat (4) @(posedge sys_clk);
      {cs_n, iow_n} <= 2'b11;
      wdata <= ~d; // Released bus shows no stale data
      repeat (3) @(posedge sys_clk);
   endtask
   // Read a register or the summary; held until the bus is driven
   task automatic rd(input logic [2:0] a, input logic s, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      addr <= a;
      if (s) summary_select_n <= 1'b0;
      else {cs_n, ior_n} <= 2'b00;
      do begin
         @(posedge sys_clk);
         n++;
      end while (data_oe_n !== 1'b0 && n < 8);
      d = data_out;
      {cs_n, ior_n, summary_select_n} <= 3'b111;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule // urcrs_host_model

`default_nettype wire

// ---- uart_channel_reset_state_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// ====================
// Bench top: reset levels, register reads and summary model
module uart_channel_reset_state_tb_top;
   import urcrs_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   urcrs_pins_t ctl, pins;
   logic h_cs_n, h_ior_n, h_iow_n, h_ss_n;
   logic [2:0] h_addr;
   logic [7:0] h_wdata, data_out, rd_d, dl, dh, src, lsin;
   logic rx_av, tx_sp, txs, data_oe_n, tx_out, ir_tx, rts_n, dtr_n, rxr_n, txr_n;
   logic int_out, int_oe_n, irq_n, irq_oe_n;
   logic [3:0] all_rx, all_tx, m;
   logic [2:0] offs [4] = '{3'h1, 3'h3, 3'h4, 3'h7};
   logic [7:0] exps [4] = '{8'h00, 8'h00, 8'h00, 8'hff};
   urcrs_divisor_t div;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;

   // Clock at 200 MHz
   always #2.5 sys_clk = ~sys_clk;

   // Pin bundle from host strobes and bench levels
   always_comb begin
      pins = ctl;
      {pins.cs_n, pins.ior_n, pins.iow_n, pins.summary_select_n} = {h_cs_n, h_ior_n, h_iow_n, h_ss_n};
      {pins.addr, pins.wdata} = {h_addr, h_wdata};
   end

   urcrs_host_model host (.sys_clk(sys_clk), .data_out(data_out), .data_oe_n(data_oe_n),
      .cs_n(h_cs_n), .ior_n(h_ior_n), .iow_n(h_iow_n), .summary_select_n(h_ss_n),
      .addr(h_addr), .wdata(h_wdata));

   urcrs_channel #(.CHAN(0)) dut (.sys_clk(sys_clk), .rstn(rstn), .pins(pins),
      .rx_data_in(8'h00), .irq_src_in(src), .line_status_in(lsin), .tx_serial_in(txs),
      .rx_avail_in(rx_av), .tx_space_in(tx_sp), .all_rx_ready_n(all_rx), .all_tx_ready_n(all_tx),
      .data_out(data_out), .data_oe_n(data_oe_n), .tx_out(tx_out), .infrared_tx_out(ir_tx),
      .rts_n_out(rts_n), .dtr_n_out(dtr_n), .rx_ready_n_out(rxr_n), .tx_ready_n_out(txr_n),
      .int_out(int_out), .int_oe_n(int_oe_n), .irq_n_out(irq_n), .irq_n_oe_n(irq_oe_n),
      .divisor_out(div));

   // ====================
   // Compare, close and pulse helpers
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic hw_pulse();
      ctl.hw_reset <= 1'b1;
      {src, lsin, txs} <= {8'h00, 8'h00, 1'b0}; // Inputs that the reset must mask
      repeat (4) @(posedge sys_clk);
      chk("rst_out", {tx_out, ir_tx, int_out}, 3'b100);
      ctl.hw_reset <= 1'b0;
      {src, lsin, txs} <= {8'h01, 8'h60, 1'b1};
      repeat (4) @(posedge sys_clk);
   endtask

   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         close_out();
      end
   end

   // ====================
   // Main sequence
   initial begin
      void'($urandom(79428));
      ctl = '0;
      {ctl.rw, ctl.cts_n, ctl.dsr_n, ctl.ri_n, ctl.cd_n} = 5'h1f;
      {rx_av, tx_sp, all_rx, all_tx} = 10'h1f0;
      {src, lsin, txs} = {8'h01, 8'h60, 1'b1};
      repeat (8) @(posedge sys_clk);
      chk("pins", {tx_out, ir_tx, rts_n, dtr_n, rxr_n, txr_n, int_oe_n, irq_oe_n, data_oe_n}, 9'h177);
      chk("div", div, 24'h000100);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      // Divisor survives the reset pin, the rest returns to defaults
      dl = 8'($urandom);
      dh = 8'($urandom);
      host.wr(3'h3, 8'h80);
      host.wr(3'h0, dl);
      host.wr(3'h1, dh);
      host.wr(3'h3, 8'h03);
      host.wr(3'h7, dl ^ dh);
      host.wr(3'h4, 8'h03);
      chk("mdm_on", {rts_n, dtr_n}, 2'b00);
      chk("div_w", div[23:8], {dh, dl});
      hw_pulse();
      chk("div_keep", div[23:8], {dh, dl});
      chk("mdm_off", {rts_n, dtr_n}, 2'b11);
      for (int i = 0; i < 4; i++) begin
         host.rd(offs[i], 1'b0, rd_d);
         chk("reg", rd_d, exps[i]);
      end
      // Modem status after reset with random pin levels
      repeat (3) begin
         m = 4'($urandom);
         {ctl.cd_n, ctl.ri_n, ctl.dsr_n, ctl.cts_n} <= m;
         repeat (4) @(posedge sys_clk);
         hw_pulse();
         host.rd(3'h6, 1'b0, rd_d);
         chk("msr", rd_d, {~m, 4'h0});
      end
      // Interrupt pin state in 16 mode at both select levels and in 68 mode with select low
      for (int i = 0; i < 4; i++) begin
         {ctl.mode_68, ctl.irq_drive_select} <= i[1:0];
         hw_pulse();
         if (i < 2) chk("int_oe", int_oe_n, !i[0]);
         if (i == 1) chk("int", int_out, 1'b0);
         if (!i[0]) chk("irq_oe", {irq_n, irq_oe_n}, 2'b01);
      end
      ctl.mode_68 <= 1'b0;
      repeat (3) @(posedge sys_clk);
      // Summary against the ready levels of all channels
      repeat (6) begin
         {rx_av, tx_sp, all_rx, all_tx} <= 10'($urandom);
         repeat (3) @(posedge sys_clk);
         host.rd(3'h0, 1'b1, rd_d);
         chk("rdy", {rxr_n, txr_n}, {!rx_av, !tx_sp});
         chk("summary", rd_d, {all_rx[3:1], !rx_av, ~all_tx[3:1], tx_sp});
      end
      // Power-up reset in mid-run reloads the power-up divisor, not the written one
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("div_por", div, 24'h000100);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      close_out();
   end
endmodule // uart_channel_reset_state_tb_top

`default_nettype wire
